// >>> rtl/dual_bus_receive_status_host_port.sv
// host register port, receive status flags and transmit window of the dual bus transceiver
//
// Operation
// R1 - status bit 11 is the bus B word received flag, like bus A
// R2 - status bit 12 holds sync type of last bus B word
// R3 - status bit 13 shows bus B idle, like bus A
// R4 - status bit 14 flags a wrongly encoded word on bus B
// R5 - status bit 15 rises about 3.5 us after a word starts sending
// R6 - transmit window bit falls about 18.5 us after word start
// R7 - word written while window is high follows back to back
// R8 - select high picks status word; low picks bus A or B word
// R9 - host reads a word by strobing low with direction high, select low
// R10 - sync pin shows command or data prefix during a received word read
// R11 - bits 8 and 12 keep last prefix until next word on that bus
// R12 - bits 2 and 3 enable each receiver; disabled bus is ignored
// R13 - receivers also decode the device's own transmitted words
// R14 - word received flag sets on new word, clears on read or next start
// R15 - bus choice is mode bit OR external pin; 0 is A, 1 is B
// R16 - idle reads 1 without bus activity, 0 with traffic
// R17 - coding fault goes high on wrongly encoded word
// R18 - strobes and flags handled in one clock for consistent snapshots
`timescale 1ns/1ps
`include "host_port_regs.svh"
module dual_bus_receive_status_host_port (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,

  // host parallel port
  input  wire logic                      access_pulse_n,
  input  wire logic                      read_not_write,
  input  wire logic                      reg_select,
  input  wire logic                      bus_choice_pin,
  input  wire logic [15:0]               host_data_in,
  output logic      [15:0]               host_data_out,
  output logic                           host_data_oe,
  input  wire logic                      sync_in,
  output logic                           sync_out,
  output logic                           sync_oe,

  // word received pins
  output logic                           bus_a_word_received,
  output logic                           bus_b_word_received,

  // decoder activity from the two receivers
  input  wire host_port_pkg::rx_event_t  bus_a_rx,
  input  wire host_port_pkg::rx_event_t  bus_b_rx,

  // encoder side
  output logic                           tx_valid,
  output host_port_pkg::tx_word_t        tx_word,
  output logic                           tx_start,
  output logic                           tx_off_a,
  output logic                           tx_off_b,
  output logic                           tx_busy,
  output logic                           tx_full
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_r;
  logic rst_n;

  // two flops so release is clean against core_clk
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ****************************************************************
  // host strobe capture
  // ****************************************************************
  logic strobe_d_r;
  logic strobe_fall;
  logic strobe_active;

  // inputs are synchronous, so a single delay gives the edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      strobe_d_r <= 1'b1;
    else
      strobe_d_r <= access_pulse_n;
  end

  assign strobe_fall   = strobe_d_r & ~access_pulse_n; // R18
  assign strobe_active = ~access_pulse_n;

  // ****************************************************************
  // control bits of the status and mode word
  // ****************************************************************
  logic [5:0]  ctrl_r;
  logic        bus_choice;
  logic        bus_a_listen_enable;
  logic        bus_b_listen_enable;
  host_port_pkg::reg_sel_t sel;
  logic        rd_word_a;
  logic        rd_word_b;
  logic        wr_status;
  logic        wr_tx;

  assign bus_a_listen_enable = ctrl_r[`SAM_LISTEN_A_BIT];
  assign bus_b_listen_enable = ctrl_r[`SAM_LISTEN_B_BIT];
  assign tx_off_a            = ctrl_r[`SAM_TX_OFF_A_BIT];
  assign tx_off_b            = ctrl_r[`SAM_TX_OFF_B_BIT];

  // register decode
  assign bus_choice = ctrl_r[`SAM_CHOICE_BIT] | bus_choice_pin; // R15
  assign sel        = reg_select ? host_port_pkg::SEL_STATUS :
                      (bus_choice ? host_port_pkg::SEL_BUS_B : host_port_pkg::SEL_BUS_A); // R8
  assign rd_word_a  = strobe_fall & read_not_write & (sel == host_port_pkg::SEL_BUS_A); // R9
  assign rd_word_b  = strobe_fall & read_not_write & (sel == host_port_pkg::SEL_BUS_B);
  assign wr_status  = strobe_fall & ~read_not_write & (sel == host_port_pkg::SEL_STATUS);
  assign wr_tx      = strobe_fall & ~read_not_write & ~reg_select;

  // writable mode bits only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      ctrl_r <= `SAM_CTRL_RESET;
    else if (wr_status)
      ctrl_r <= host_data_in[5:0]; // R12
  end

  // ****************************************************************
  // per bus receive state
  // ****************************************************************
  logic [1:0]  rcv_r;
  logic [1:0]  prefix_r;
  logic [1:0]  idle_r;
  logic [1:0]  fault_r;
  logic [15:0] word_r [2];
  logic [1:0]  listen;
  logic [1:0]  rd_word;
  host_port_pkg::rx_event_t rx_ev [2];

  // loopback of own transmissions reaches these inputs too, so the
  // receivers see the device's own words like any other traffic
  assign rx_ev[0] = bus_a_rx; // R13
  assign rx_ev[1] = bus_b_rx;
  assign listen   = {bus_b_listen_enable, bus_a_listen_enable};
  assign rd_word  = {rd_word_b, rd_word_a};

  generate
    for (genvar b = 0; b < 2; b++) begin : g_bus
      logic en_done;
      logic en_start;
      logic en_fault;
      assign en_done  = listen[b] & rx_ev[b].word_done;
      assign en_start = listen[b] & rx_ev[b].word_start;
      assign en_fault = listen[b] & rx_ev[b].fault;

      // word received flag: arrival wins over a clear in the same cycle
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
          rcv_r[b] <= 1'b0;
        else if (en_done)
          rcv_r[b] <= 1'b1; // R14 R1
        else if (rd_word[b] | en_start)
          rcv_r[b] <= 1'b0; // R14
      end

      // word and prefix kept until the next word lands
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          prefix_r[b] <= 1'b0;
          word_r[b]   <= 16'h0000;
        end else if (en_done) begin
          prefix_r[b] <= rx_ev[b].word.prefix; // R11 R2
          word_r[b]   <= rx_ev[b].word.data;
        end
      end

      // idle and coding fault; disabled bus counts as idle
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          idle_r[b]  <= 1'b0;
          fault_r[b] <= 1'b0;
        end else begin
          idle_r[b] <= ~(listen[b] & rx_ev[b].busy); // R16 R3
          if (en_fault)
            fault_r[b] <= 1'b1; // R17 R4
          else if (en_done)
            fault_r[b] <= 1'b0;
        end
      end
    end
  endgenerate

  assign bus_a_word_received = rcv_r[0];
  assign bus_b_word_received = rcv_r[1];

  // ****************************************************************
  // transmit queue and window timing
  // ****************************************************************
  localparam logic [7:0] OPEN_CYC  = 8'(`WIN_OPEN_CYC);
  localparam logic [7:0] CLOSE_CYC = 8'(`WIN_CLOSE_CYC);
  localparam logic [7:0] WORD_CYC  = 8'(`WORD_CYC);

  host_port_pkg::tx_state_t st_r;
  host_port_pkg::tx_state_t st_nxt;
  host_port_pkg::tx_word_t  tx_in;
  logic [7:0]  cnt_r;
  logic        window_r;
  logic        fifo_ready;
  logic        fifo_valid;
  logic        take;
  logic        word_end;

  assign tx_in    = '{bus: bus_choice, prefix: ctrl_r[`SAM_TX_PREFIX_BIT] | sync_in,
                      data: host_data_in};
  assign tx_full  = ~fifo_ready;
  assign word_end = (cnt_r == WORD_CYC - 8'h01);
  // next word starts at idle or right at the end of the current one
  assign take     = fifo_valid & ((st_r == host_port_pkg::TX_IDLE) | word_end); // R7
  assign tx_start = take;
  assign tx_valid = take;
  assign tx_busy  = (st_r != host_port_pkg::TX_IDLE);

  // a full queue drops the write; the host should poll the window bit
  word_fifo #(
    .WIDTH ($bits(host_port_pkg::tx_word_t)),
    .DEPTH (`FIFO_DEPTH)
  ) u_tx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (wr_tx),
    .in_ready  (fifo_ready),
    .in_data   (tx_in),
    .out_valid (fifo_valid),
    .out_ready (take),
    .out_data  (tx_word)
  );

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      host_port_pkg::TX_IDLE: begin
        if (take)
          st_nxt = host_port_pkg::TX_SEND;
      end
      host_port_pkg::TX_SEND: begin
        if (cnt_r == OPEN_CYC - 8'h01)
          st_nxt = host_port_pkg::TX_WINDOW;
      end
      host_port_pkg::TX_WINDOW: begin
        if (cnt_r == CLOSE_CYC - 8'h01)
          st_nxt = host_port_pkg::TX_TAIL;
      end
      host_port_pkg::TX_TAIL: begin
        if (word_end)
          st_nxt = take ? host_port_pkg::TX_SEND : host_port_pkg::TX_IDLE;
      end
      default:                  st_nxt = host_port_pkg::TX_IDLE;
    endcase
  end

  // cycle count from word start
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r  <= host_port_pkg::TX_IDLE;
      cnt_r <= 8'h00;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (take | (st_r == host_port_pkg::TX_IDLE)) ? 8'h00 : cnt_r + 8'h01;
    end
  end

  // window: high at idle, falls at 18.5 us, rises at 3.5 us into a word
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      window_r <= `WINDOW_RESET;
    else if (take)
      window_r <= 1'b0;
    else if (st_r == host_port_pkg::TX_SEND && cnt_r == OPEN_CYC - 8'h01)
      window_r <= 1'b1; // R5
    else if (st_r == host_port_pkg::TX_WINDOW && cnt_r == CLOSE_CYC - 8'h01)
      window_r <= 1'b0; // R6
    else if (st_r == host_port_pkg::TX_IDLE)
      window_r <= 1'b1;
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [15:0] status_word;
  logic [15:0] rd_mux;

  // whole status image built from one clock's flags
  assign status_word = {window_r, fault_r[1], idle_r[1], prefix_r[1], rcv_r[1],
                        fault_r[0], idle_r[0], prefix_r[0], rcv_r[0], 1'b0, ctrl_r}; // R18
  assign rd_mux      = (sel == host_port_pkg::SEL_STATUS) ? status_word :
                       (sel == host_port_pkg::SEL_BUS_B) ? word_r[1] : word_r[0];

  // data and sync are captured at the strobe edge and held while it is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_data_out <= 16'h0000;
      sync_out      <= 1'b0;
    end else if (strobe_fall) begin
      host_data_out <= rd_mux;
      sync_out      <= (sel == host_port_pkg::SEL_BUS_B) ? prefix_r[1] : prefix_r[0]; // R10
    end
  end

  assign host_data_oe = strobe_active & read_not_write & ~strobe_d_r ? 1'b1 : 1'b0;
  assign sync_oe      = host_data_oe & ~reg_select; // R10

endmodule

// >>> rtl/host_port_regs.svh
// field positions, reset values and timing counts of the host port
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ****************************************************************
// status and mode word field positions
// ****************************************************************
`define SAM_TX_OFF_A_BIT    0
`define SAM_TX_OFF_B_BIT    1
`define SAM_LISTEN_A_BIT    2
`define SAM_LISTEN_B_BIT    3
`define SAM_TX_PREFIX_BIT   4
`define SAM_CHOICE_BIT      5
`define SAM_RCV_A_BIT       7
`define SAM_PREFIX_A_BIT    8
`define SAM_IDLE_A_BIT      9
`define SAM_FAULT_A_BIT     10
`define SAM_RCV_B_BIT       11
`define SAM_PREFIX_B_BIT    12
`define SAM_IDLE_B_BIT      13
`define SAM_FAULT_B_BIT     14
`define SAM_WINDOW_BIT      15

// ****************************************************************
// write mask and reset values
// ****************************************************************
`define SAM_WRITE_MASK      16'h003F
`define SAM_CTRL_RESET      6'h0C
`define WINDOW_RESET        1'b1

// ****************************************************************
// timing (core clock 10 MHz)
// ****************************************************************
`define CORE_CLK_HZ         10000000
`define WIN_OPEN_NS         3500
`define WIN_CLOSE_NS        18500
`define WIN_OPEN_CYC        ((`WIN_OPEN_NS * (`CORE_CLK_HZ / 1000000)) / 1000)
`define WIN_CLOSE_CYC       ((`WIN_CLOSE_NS * (`CORE_CLK_HZ / 1000000)) / 1000)
`define WORD_CYC            200
`define FIFO_DEPTH          16

`endif

// >>> rtl/host_port_pkg.sv
// types shared by the dual bus host port
package host_port_pkg;

  // one decoded word handed up by a bus receiver
  typedef struct packed {
    logic        prefix;      // 1 = command prefix, 0 = data prefix
    logic [15:0] data;
  } rx_word_t;

  // receiver activity seen on one bus
  typedef struct packed {
    logic     word_start;     // start of an incoming word detected
    logic     word_done;      // word decoded correctly, pulse
    logic     fault;          // wrongly encoded word, pulse
    logic     busy;           // traffic present
    rx_word_t word;
  } rx_event_t;

  // word queued for the encoder
  typedef struct packed {
    logic        bus;
    logic        prefix;
    logic [15:0] data;
  } tx_word_t;

  // host access decode
  typedef enum logic [1:0] {
    SEL_BUS_A  = 2'b00,
    SEL_BUS_B  = 2'b01,
    SEL_STATUS = 2'b11
  } reg_sel_t;

  // transmit sequencer, gray coded along idle -> sending -> window
  typedef enum logic [1:0] {
    TX_IDLE   = 2'b00,
    TX_SEND   = 2'b01,
    TX_WINDOW = 2'b11,
    TX_TAIL   = 2'b10
  } tx_state_t;

endpackage

// >>> rtl/word_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      rd_ptr_nxt;
  logic             push;
  logic             pop;
  logic             empty;

  // full when pointers differ only in the wrap bit
  assign empty      = (wr_ptr_r == rd_ptr_r);
  assign in_ready   = ~((wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]));
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign rd_ptr_nxt = rd_ptr_r + (AW+1)'(1);

  // pointers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      out_valid <= 1'b0;
    end else begin
      if (push)
        wr_ptr_r <= wr_ptr_r + (AW+1)'(1);
      if (pop)
        rd_ptr_r <= rd_ptr_nxt;
      out_valid <= pop ? (rd_ptr_nxt != wr_ptr_r) || push : ~empty;
    end
  end

  // storage and registered read data; a push into the next head bypasses memory
  always_ff @(posedge core_clk) begin
    if (push)
      mem_r[wr_ptr_r[AW-1:0]] <= in_data;
    out_data <= (pop && push && rd_ptr_nxt == wr_ptr_r) ? in_data :
                pop ? mem_r[rd_ptr_nxt[AW-1:0]] : mem_r[rd_ptr_r[AW-1:0]];
  end

endmodule

// >>> tb/host_port_properties.sv
// checker of the host port relations over time
`timescale 1ns/1ps
module host_port_properties (
  // clock and reset
  input wire logic                     core_clk,
  input wire logic                     rstn,
  // host port
  input wire logic                     access_pulse_n,
  input wire logic                     read_not_write,
  input wire logic                     reg_select,
  input wire logic                     bus_choice_pin,
  input wire logic [15:0]              host_data_out,
  input wire logic                     host_data_oe,
  input wire logic                     sync_oe,
  // flags and receivers
  input wire logic                     bus_a_word_received,
  input wire logic                     bus_b_word_received,
  input wire host_port_pkg::rx_event_t bus_a_rx,
  input wire host_port_pkg::rx_event_t bus_b_rx,
  // encoder side
  input wire logic                     tx_start,
  input wire logic                     tx_valid
);
  // ****************************************
  // helper state
  // ****************************************
  logic       strobe_q_r;  // previous strobe sample
  logic [8:0] gap_r;       // cycles since last start, saturating
  logic       seen_r;      // a start has been seen
  wire        take = !access_pulse_n && strobe_q_r;

  // counter saturates so a long pause never wraps into a false short gap
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strobe_q_r <= 1'b1;
      gap_r      <= 9'h000;
      seen_r     <= 1'b0;
    end else begin
      strobe_q_r <= access_pulse_n;
      gap_r      <= tx_start ? 9'h000 : gap_r + {8'h00, gap_r != 9'h1FF};
      seen_r     <= seen_r | tx_start;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ****************************************
  // assertions
  // ****************************************
  a_sync_oe_select: assert property (sync_oe == (host_data_oe && !reg_select))
    else $error("sync enable differs from data enable on word read");
  a_oe_only_read: assert property (host_data_oe |-> !access_pulse_n && read_not_write)
    else $error("data driven outside a read strobe");
  a_oe_second_cycle: assert property (!access_pulse_n && !strobe_q_r && read_not_write
    |-> host_data_oe)
    else $error("data not driven on second strobe cycle");
  a_flag_a_cause: assert property ($rose(bus_a_word_received) |-> $past(bus_a_rx.word_done))
    else $error("bus a flag rose without a word");
  a_flag_b_cause: assert property ($rose(bus_b_word_received) |-> $past(bus_b_rx.word_done))
    else $error("bus b flag rose without a word");
  a_start_clears_a: assert property (bus_a_rx.word_start && !bus_a_rx.word_done
    |=> !bus_a_word_received)
    else $error("bus a flag kept after word start");
  a_read_clears_b: assert property (take && read_not_write && !reg_select && bus_choice_pin
    && !bus_b_rx.word_done |=> !bus_b_word_received)
    else $error("bus b flag kept after word read");
  a_snapshot_flags: assert property (take && read_not_write && reg_select |=>
    host_data_out[11] == $past(bus_b_word_received)
    && host_data_out[7] == $past(bus_a_word_received) && !host_data_out[6])
    else $error("status snapshot differs from flag pins");
  a_word_spacing: assert property (tx_start && seen_r |-> gap_r >= 9'd199)
    else $error("word started before previous one ended");
  a_start_single: assert property (tx_start |-> tx_valid ##1 !tx_start)
    else $error("start pulse malformed");
endmodule

// >>> tb/host_bus_model.sv
// host processor model driving the strobed register port
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic        core_clk,
  // strobed port
  output logic             access_pulse_n,
  output logic             read_not_write,
  output logic             reg_select,
  output logic             bus_choice_pin,
  output logic [15:0]      host_data_in,
  output logic             sync_in,
  input  wire logic [15:0] host_data_out,
  input  wire logic        sync_out
);
  // idle bus at time zero
  initial begin
    access_pulse_n = 1'b1;
    read_not_write = 1'b1;
    reg_select     = 1'b0;
    bus_choice_pin = 1'b0;
    host_data_in   = 16'h0000;
    sync_in        = 1'b0;
  end

  // one access, answer taken at the second rising edge
  task automatic access(input logic rnw, sel, ch, sy, input logic [15:0] wd,
                        output logic [15:0] rd, output logic rs);
    @(negedge core_clk);
    read_not_write = rnw;
    reg_select     = sel;
    bus_choice_pin = ch;
    host_data_in   = wd;
    sync_in        = sy;
    access_pulse_n = 1'b0;
    repeat (2) @(posedge core_clk);
    rd = host_data_out;
    rs = sync_out;
    @(negedge core_clk);
    access_pulse_n = 1'b1;
    host_data_in   = ~wd;       // released line must not look held
    sync_in        = ~sy;
    @(negedge core_clk);        // strobe high at least one cycle
  endtask
endmodule

// >>> tb/dual_bus_receive_status_host_port_tb.sv
// testbench of the dual bus host port
`timescale 1ns/1ps
module dual_bus_receive_status_host_port_tb;
  logic                     core_clk, rstn, last_sync, saw_full;
  logic                     access_pulse_n, read_not_write, reg_select, bus_choice_pin;
  logic                     sync_in, sync_out, sync_oe, host_data_oe;
  logic [15:0]              host_data_in, host_data_out;
  logic                     bus_a_word_received, bus_b_word_received;
  host_port_pkg::rx_event_t bus_a_rx, bus_b_rx;
  host_port_pkg::tx_word_t  tx_word;
  logic                     tx_valid, tx_start, tx_off_a, tx_off_b, tx_busy, tx_full;
  int                       n_mismatch, checked, cyc;
  logic [17:0]              st_word[$];
  int                       st_cyc[$];

  // ****************************************
  // clock, instances, start log
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  dual_bus_receive_status_host_port u_dual_bus_receive_status_host_port (.*);

  host_bus_model u_host_bus_model (.*);

  // record every word start with its cycle
  always @(posedge core_clk) begin
    cyc++;
    if (tx_start === 1'b1) begin
      st_word.push_back(tx_word);
      st_cyc.push_back(cyc);
    end
    if (tx_full === 1'b1) saw_full = 1'b1;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cmp16(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic rd(input logic sel, ch, output logic [15:0] d);
    u_host_bus_model.access(1'b1, sel, ch, 1'b0, 16'h0000, d, last_sync);
  endtask
  task automatic wr(input logic sel, ch, sy, input logic [15:0] w);
    logic [15:0] d;
    logic        s;
    u_host_bus_model.access(1'b0, sel, ch, sy, w, d, s);
  endtask
  // one-cycle decoder event with traffic shown; busy drops afterwards
  task automatic rx(input logic b, st, dn, ft, pf, input logic [15:0] w);
    host_port_pkg::rx_event_t e;
    e = {st, dn, ft, 1'b1, pf, w};
    @(negedge core_clk);
    if (b) bus_b_rx = e; else bus_a_rx = e;
    @(negedge core_clk);
    if (b) bus_b_rx = {4'h0, e.word}; else bus_a_rx = {4'h0, e.word};
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [15:0] d;
    rd(1'b1, 1'b0, d);
    cmp16("status after reset", 16'hA20C, d);
    $display("test reset done");
  endtask

  task automatic t_rx_read;
    logic [15:0] d;
    for (int b = 0; b < 2; b++) begin
      rx(b[0], 1'b0, 1'b1, 1'b0, 1'b1, 16'hC3A5 ^ b[15:0]);
      cmp1("flag pin", 1'b1, b ? bus_b_word_received : bus_a_word_received);
      rd(1'b1, 1'b0, d);
      cmp16("flags and prefixes", b ? 16'h1900 : 16'h0180, d & 16'h1980);
      rd(1'b0, b[0], d);
      cmp16("received word", 16'hC3A5 ^ b[15:0], d);
      cmp1("sync pin", 1'b1, last_sync);
      cmp1("flag after read", 1'b0, b ? bus_b_word_received : bus_a_word_received);
    end
    rx(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0F0F);
    rx(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0F0F);
    cmp1("flag after next start", 1'b0, bus_a_word_received);
    rd(1'b1, 1'b0, d);
    cmp16("kept prefixes", 16'h1000, d & 16'h1980);
    rd(1'b0, 1'b0, d);
    cmp16("word after start", 16'h0F0F, d);
    cmp1("data sync pin", 1'b0, last_sync);
    $display("test receive and read done");
  endtask

  task automatic t_idle_fault;
    logic [15:0] d;
    for (int b = 0; b < 2; b++) begin
      @(negedge core_clk);
      if (b) bus_b_rx.busy = 1'b1; else bus_a_rx.busy = 1'b1;
      repeat (2) @(negedge core_clk);
      rd(1'b1, 1'b0, d);
      cmp16("idle bits", b ? 16'h0200 : 16'h2000, d & 16'h2200);
      rx(b[0], 1'b0, 1'b0, 1'b1, 1'b0, 16'h0000);
      rd(1'b1, 1'b0, d);
      cmp16("fault bits", b ? 16'h6200 : 16'h2600, d & 16'h6600);
      rx(b[0], 1'b0, 1'b1, 1'b0, 1'b0, 16'h55AA);
      rd(1'b1, 1'b0, d);
      cmp16("fault after good word", 16'h0000, d & 16'h4400);
      rd(1'b0, b[0], d);
    end
    $display("test idle and fault done");
  endtask

  task automatic t_mode;
    logic [15:0] d;
    wr(1'b1, 1'b0, 1'b0, 16'hFFFF);
    rd(1'b1, 1'b0, d);
    cmp16("mode bits", 16'h003F, d & 16'h007F);
    cmp16("tx off", 16'h0003, {14'h0000, tx_off_b, tx_off_a});
    rx(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h7E81);
    rd(1'b0, 1'b0, d);
    cmp16("word via mode choice", 16'h7E81, d);
    wr(1'b1, 1'b0, 1'b0, 16'h0000);
    rx(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h1111);
    rx(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 16'h2222);
    rd(1'b1, 1'b0, d);
    cmp16("listeners off", 16'h2200, d & 16'h2A8C);
    wr(1'b1, 1'b0, 1'b0, 16'h000C);
    $display("test mode done");
  endtask

  task automatic win_at(input int t0, t, input logic e);
    logic [15:0] d;
    while (cyc - t0 < t) @(negedge core_clk);
    rd(1'b1, 1'b0, d);
    cmp1("window bit", e, d[15]);
  endtask

  task automatic t_window;
    int n;
    int t0;
    n = st_word.size();
    wr(1'b0, 1'b0, 1'b1, 16'hA5A5);
    for (int k = 0; k < 20 && st_word.size() == n; k++) @(negedge core_clk);
    t0 = cyc;
    cmp16("sent word", 16'hA5A5, st_word[n][15:0]);
    cmp16("sent bus and prefix", 16'h0001, 16'(st_word[n][17:16]));
    win_at(t0, 8, 1'b0);
    win_at(t0, 50, 1'b1);
    win_at(t0, 170, 1'b1);
    win_at(t0, 192, 1'b0);
    $display("test window done");
  endtask

  // queue filled while first word sends, then drained back to back
  task automatic t_queue;
    int n;
    for (int k = 0; k < 400 && tx_busy !== 1'b0; k++) @(negedge core_clk);
    n = st_word.size();
    saw_full = 1'b0;
    for (int i = 0; i < 18; i++) wr(1'b0, 1'b1, i[0], 16'h0100 + i[15:0]);
    cmp1("queue full seen", 1'b1, saw_full);
    for (int k = 0; k < 4000 && tx_busy !== 1'b0; k++) @(negedge core_clk);
    cmp16("words sent", 16'd17, 16'(st_word.size() - n));
    for (int i = 0; i < 17 && n + i < st_word.size(); i++) begin
      cmp16("queued word", 16'h0100 + i[15:0], st_word[n+i][15:0]);
      cmp16("queued bus and prefix", {15'h0001, i[0]}, 16'(st_word[n+i][17:16]));
      if (i > 0) cmp16("word gap", 16'd200, 16'(st_cyc[n+i] - st_cyc[n+i-1]));
    end
    $display("test queue done");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    rstn     = 1'b0;
    bus_a_rx = '0;
    bus_b_rx = '0;
    saw_full = 1'b0;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    t_reset;
    t_rx_read;
    t_idle_fault;
    t_mode;
    t_window;
    t_queue;
    end_of_test;
  end

  // whole run needs about 3700 cycles
  initial begin
    #2000000;
    n_mismatch++;
    $display("Error watchdog expired");
    end_of_test;
  end
endmodule

bind dual_bus_receive_status_host_port host_port_properties u_host_port_properties (.*);
